// [verilog/tppio_top.v]
`include "tppio_defs.vh"

module tppio_top (
    // clock and reset
    input wire SYS_CLK,
    input wire RST,
    // apb slave
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [11:0] PADDR,
    input wire [31:0] PWDATA,
    output reg [31:0] PRDATA,
    output reg PREADY,
    output reg PSLVERR,
    // port a pins
    input wire [7:0] PA_IN,
    output wire [7:0] PA_OUT,
    output wire [7:0] PA_OE_N,
    // port b pins
    input wire [7:0] PB_IN,
    output wire [7:0] PB_OUT,
    output wire [7:0] PB_OE_N,
    // port c pins
    input wire [4:0] PC_IN,
    output wire [4:0] PC_OUT,
    output wire [4:0] PC_OE_N
);
    reg [7:0] port_a_output_latch_ff;
    reg [7:0] port_b_output_latch_ff;
    reg [4:0] port_c_output_latch_ff;
    reg [7:0] port_a_direction_ff;
    reg [7:0] port_b_direction_ff;
    reg [4:0] port_c_direction_ff;
    reg [7:0] pa_oe_n_ff;
    reg [7:0] pb_oe_n_ff;
    reg [4:0] pc_oe_n_ff;
    reg [7:0] pa_meta_ff;
    reg [7:0] pa_sync_ff;
    reg [7:0] pb_meta_ff;
    reg [7:0] pb_sync_ff;
    reg [4:0] pc_meta_ff;
    reg [4:0] pc_sync_ff;
    reg [7:0] nxt_rdata;
    reg nxt_err;

    wire access = PSEL & PENABLE & ~PREADY;
    wire wr = access & PWRITE;
    wire [2:0] idx = PADDR[4:2];
    wire word_ok = (PADDR[1:0] == 2'b00) && (PADDR[11:5] == 7'h00);

    function [7:0] rd_mux;
        input [7:0] dir;
        input [7:0] latch;
        input [7:0] pin;
        begin
            rd_mux = (dir & latch) | (~dir & pin);
        end
    endfunction

    function hit;
        input [2:0] a;
        input [2:0] b;
        input ok;
        begin
            hit = ok && (a == b);
        end
    endfunction

    // pins are asynchronous: two stages before anything reads them
    always @(posedge SYS_CLK) begin
        pa_meta_ff <= PA_IN;
        pa_sync_ff <= pa_meta_ff;
        pb_meta_ff <= PB_IN;
        pb_sync_ff <= pb_meta_ff;
        pc_meta_ff <= PC_IN;
        pc_sync_ff <= pc_meta_ff;
    end

    // data latches: no reset term on purpose
    always @(posedge SYS_CLK) begin
        if (wr && hit(idx, `TPPIO_IDX_DATA_A, word_ok)) begin
            port_a_output_latch_ff <= PWDATA[7:0];
        end
        if (wr && hit(idx, `TPPIO_IDX_DATA_B, word_ok)) begin
            port_b_output_latch_ff <= PWDATA[7:0];
        end
        if (wr && hit(idx, `TPPIO_IDX_DATA_C, word_ok)) begin
            port_c_output_latch_ff <= PWDATA[4:0];
        end
    end

    // direction registers and buffered enables
    always @(posedge SYS_CLK) begin
        if (RST) begin
            port_a_direction_ff <= `TPPIO_DIR_RESET;
            port_b_direction_ff <= `TPPIO_DIR_RESET;
            port_c_direction_ff <= 5'h00;
        end else if (wr) begin
            if (hit(idx, `TPPIO_IDX_DIR_A, word_ok)) begin
                port_a_direction_ff <= PWDATA[7:0];
            end else if (hit(idx, `TPPIO_IDX_DIR_B, word_ok)) begin
                port_b_direction_ff <= PWDATA[7:0];
            end else if (hit(idx, `TPPIO_IDX_DIR_C, word_ok)) begin
                port_c_direction_ff <= PWDATA[4:0];
            end
        end
    end

    // enable follows the direction register by one edge, keeping outputs flopped
    always @(posedge SYS_CLK) begin
        if (RST) begin
            pa_oe_n_ff <= 8'hFF;
            pb_oe_n_ff <= 8'hFF;
            pc_oe_n_ff <= 5'h1F;
        end else begin
            pa_oe_n_ff <= ~port_a_direction_ff;
            pb_oe_n_ff <= ~port_b_direction_ff;
            pc_oe_n_ff <= ~port_c_direction_ff;
        end
    end

    // latch bits are driven out directly; the enable decides if they reach the pin
    assign PA_OUT = port_a_output_latch_ff;
    assign PB_OUT = port_b_output_latch_ff;
    assign PC_OUT = port_c_output_latch_ff;
    assign PA_OE_N = pa_oe_n_ff;
    assign PB_OE_N = pb_oe_n_ff;
    assign PC_OE_N = pc_oe_n_ff;

    always @* begin
        nxt_rdata = 8'h00;
        nxt_err = 1'b0;
        if (!word_ok) begin
            nxt_err = 1'b1;
        end else if (idx == `TPPIO_IDX_DATA_A) begin
            nxt_rdata = rd_mux(port_a_direction_ff, port_a_output_latch_ff, pa_sync_ff);
        end else if (idx == `TPPIO_IDX_DATA_B) begin
            nxt_rdata = rd_mux(port_b_direction_ff, port_b_output_latch_ff, pb_sync_ff);
        end else if (idx == `TPPIO_IDX_DATA_C) begin
            nxt_rdata = rd_mux({3'h0, port_c_direction_ff}, {3'h0, port_c_output_latch_ff},
                {3'h0, pc_sync_ff});
        end else if (idx == `TPPIO_IDX_DIR_A) begin
            nxt_rdata = port_a_direction_ff;
        end else if (idx == `TPPIO_IDX_DIR_B) begin
            nxt_rdata = port_b_direction_ff;
        end else if (idx == `TPPIO_IDX_DIR_C) begin
            nxt_rdata = {3'h0, port_c_direction_ff};
        end else begin
            nxt_err = 1'b1;
        end
    end

    // one wait state: ready rises on the first access edge, the transfer ends on the second
    always @(posedge SYS_CLK) begin
        if (RST) begin
            PREADY <= 1'b0;
            PRDATA <= 32'h00000000;
            PSLVERR <= 1'b0;
        end else if (access) begin
            PREADY <= 1'b1;
            PRDATA <= PWRITE ? 32'h00000000 : {24'h000000, nxt_rdata};
            PSLVERR <= nxt_err;
        end else begin
            PREADY <= 1'b0;
            PRDATA <= 32'h00000000;
            PSLVERR <= 1'b0;
        end
    end
endmodule

// [include/tppio_defs.vh]
// Functional notes
// - port a has eight bidirectional pins, each with its own latch bit
// - port a data latches keep their value through reset
// - port a direction one drives latch onto pin, zero leaves pin undriven
// - reset clears all port a direction bits, pins become inputs
// - data read returns latch value for bits whose direction is one
// - data read returns pin level for bits whose direction is zero
// - data register writes always update latches regardless of direction
// - writing latch of an input pin does not change sampled pin value
// - port b has eight bidirectional pins, each with its own latch bit
// - port b data latches keep their value through reset
// - port b direction one enables output buffer, zero disables it
// - reset clears all port b direction bits, pins become inputs
// - port b read gives latch where output, pin level where input
// - port c data has latches in bits 4..0 only, upper bits read zero
// - port c direction has bits 4..0, upper read zero, reset clears all
// - port c behaves like ports a and b bit for bit, five pins
// - port c read gives latch where output, pin level where input
`ifndef TPPIO_DEFS_VH
`define TPPIO_DEFS_VH
`define TPPIO_IDX_DATA_A 3'h0
`define TPPIO_IDX_DATA_B 3'h1
`define TPPIO_IDX_DATA_C 3'h2
`define TPPIO_IDX_DIR_A 3'h4
`define TPPIO_IDX_DIR_B 3'h5
`define TPPIO_IDX_DIR_C 3'h6
`define TPPIO_DIR_RESET 8'h00
`define TPPIO_WIDTH_A 8
`define TPPIO_WIDTH_B 8
`define TPPIO_WIDTH_C 5
`endif

// [test/tppio_props.sv]
module tppio_props (
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic RST,
    // bus
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    // pins
    input wire logic [7:0] PA_OUT,
    input wire logic [7:0] PA_OE_N,
    input wire logic [4:0] PC_OUT,
    input wire logic [4:0] PC_OE_N
);
    timeunit 1ns;
    timeprecision 1ps;
    wire logic acc = PSEL && PENABLE && !PREADY;
    default clocking @(posedge SYS_CLK);
    endclocking
    default disable iff (RST);
    a_ready_wait: assert property (acc |=> PREADY)
        else $error("ready late");
    a_ready_pulse: assert property (PREADY |=> !PREADY)
        else $error("ready too long");
    a_write_a: assert property (acc && PWRITE && PADDR == 12'h0 |=> PA_OUT == $past(PWDATA[7:0]))
        else $error("latch a not written");
    a_write_c: assert property (acc && PWRITE && PADDR == 12'h8 |=> PC_OUT == $past(PWDATA[4:0]))
        else $error("latch c not written");
    a_dir_drive: assert property (acc && PWRITE && PADDR == 12'h10 |=> ##1 PA_OE_N == ~$past(PWDATA[7:0], 2))
        else $error("buffer a wrong");
    a_c_upper: assert property (PREADY && (PADDR == 12'h8 || PADDR == 12'h18) |-> PRDATA[31:5] == 27'h0)
        else $error("port c upper bits set");
    a_read_latch: assert property (PREADY && !PWRITE && PADDR == 12'h0 && $stable(PA_OE_N) |-> ((PRDATA[7:0] ^ PA_OUT) & ~PA_OE_N) == 8'h0)
        else $error("output bit not latch");
    a_dir_reset: assert property ($fell(RST) |-> PA_OE_N == 8'hFF && PC_OE_N == 5'h1F)
        else $error("buffers on after reset");
endmodule
bind tppio_top tppio_props u_props (.SYS_CLK, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
    .PRDATA, .PREADY, .PA_OUT, .PA_OE_N, .PC_OUT, .PC_OE_N);

// [test/tppio_pins.sv]
module tppio_pins (
    // device buffers
    input wire logic [20:0] out,
    input wire logic [20:0] oe_n,
    // board levels
    input wire logic [20:0] ext,
    output logic [20:0] pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // board only wins where the buffer is off
    assign pin = (out & ~oe_n) | (ext & oe_n);
endmodule

// [test/tppio_tb_top.sv]
module tppio_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin errors++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, a, e); end end
    logic SYS_CLK = 0, RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, PREADY, PSLVERR, er;
    logic [11:0] PADDR = 12'h0;
    logic [31:0] PWDATA = 32'h0, PRDATA, rd;
    logic [7:0] PA_OUT, PA_OE_N, PB_OUT, PB_OE_N;
    logic [4:0] PC_OUT, PC_OE_N;
    logic [20:0] ext = {8'h3C, 8'h96, 5'h0A};
    wire logic [20:0] pins;
    int errors = 0, comparisons = 0;
    typedef struct {logic w; logic [11:0] a; logic [7:0] v; logic er;} tppio_row_t;
    // v is write data for writes, expected read data for reads
    tppio_row_t rows[17] = '{'{0, 12'h10, 8'h0, 0}, '{0, 12'h14, 8'h0, 0}, '{0, 12'h18, 8'h0, 0},
        '{1, 12'h0, 8'h5A, 0}, '{0, 12'h0, 8'h3C, 0}, '{1, 12'h10, 8'hF0, 0},
        '{0, 12'h0, 8'h5C, 0}, '{0, 12'h10, 8'hF0, 0}, '{1, 12'h4, 8'hA5, 0},
        '{1, 12'h14, 8'hFF, 0}, '{0, 12'h4, 8'hA5, 0}, '{0, 12'h8, 8'h0A, 0},
        '{1, 12'h8, 8'hFF, 0}, '{1, 12'h18, 8'hFF, 0}, '{0, 12'h18, 8'h1F, 0},
        '{0, 12'h8, 8'h1F, 0}, '{0, 12'hC, 8'h0, 1}};
    always #12.5 SYS_CLK = ~SYS_CLK;
    tppio_top dut (.SYS_CLK, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY,
        .PSLVERR, .PA_IN(pins[20:13]), .PA_OUT, .PA_OE_N, .PB_IN(pins[12:5]), .PB_OUT,
        .PB_OE_N, .PC_IN(pins[4:0]), .PC_OUT, .PC_OE_N);
    tppio_pins board (.out({PA_OUT, PB_OUT, PC_OUT}), .oe_n({PA_OE_N, PB_OE_N, PC_OE_N}),
        .ext, .pin(pins));
    task automatic conclude();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // idle cycle first, so a release never meets a new setup in one step
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        int n = 0;
        @(posedge SYS_CLK);
        PSEL <= 1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= {24'h0, d};
        @(posedge SYS_CLK);
        PENABLE <= 1;
        do begin
            @(posedge SYS_CLK);
            n++;
        end while (PREADY !== 1'b1 && n < 16);
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 0;
        PENABLE <= 0;
        if (n >= 16) begin
            errors++;
            conclude();
        end
    endtask
    initial begin
        repeat (2) @(posedge SYS_CLK);
        RST <= 0;
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].v);
            `CHK(er, rows[i].er)
            if (!rows[i].w) `CHK(rd[7:0], rows[i].v)
        end
        `CHK(PB_OE_N, 8'h00)
        ext[20:13] <= 8'hC3;
        repeat (4) @(posedge SYS_CLK);
        apb(0, 12'h0, 8'h0);
        `CHK(rd[7:0], 8'h53)
        RST <= 1;
        repeat (2) @(posedge SYS_CLK);
        RST <= 0;
        @(posedge SYS_CLK);
        #1;
        `CHK({PA_OUT, PB_OUT, PC_OUT}, {8'h5A, 8'hA5, 5'h1F})
        `CHK({PA_OE_N, PB_OE_N, PC_OE_N}, 21'h1FFFFF)
        conclude();
    end
endmodule
